// *** src/codec_host_ctrl.sv ***
// host controller for a six-channel codec: serial audio master,
// auxiliary source, spi control master, power-down and pin straps.
// assumes an axi4-lite master on core_clk and codec pins outside it.
//
// Contract
// - serial_in_a carries dac 1/2 samples, also the one-line input.
// - serial_in_b carries dac 3/4 samples.
// - serial_in_c carries dac 5/6 samples.
// - bit clock shifts data; edge follows the clock polarity bit.
// - word clock runs at sample rate; alignment follows the format.
// - aux word clock at sample rate, driven by source in slave mode.
// - aux bit clock shifts aux data, driven by source in slave mode.
// - control interface clock moves control bits in and out.
// - shared_addr0_select is address bit in i2c, chip select low in spi.
// - shared_addr1_datain is address bit in i2c, data in for spi.
// - control data pin is i2c data, or spi data out.
// - after power-down rises, host clears chip reset before operation.
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module codec_host_ctrl (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [codec_host_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [codec_host_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic serialInA,
	output logic serialInB,
	output logic serialInC,
	input wire logic serialOutA,
	input wire logic serialOutB,
	output logic portBitClock,
	output logic portWordClock,
	output logic deemphPinN,
	input wire logic overloadFlag,
	output logic auxDataIn,
	output logic auxWordClock,
	output logic auxBitClock,
	output logic frameRepeatReq,
	output logic controlFormatSel,
	output logic controlInterfaceClock,
	output logic sharedAddr0SelectN,
	output logic sharedAddr1Datain,
	input wire logic controlDataPin,
	output logic powerDownInputN
);
	import codec_host_pkg::*;

	lane_ctl_if laneCtl ();

	logic [3:0] syncAQ, syncBQ;
	logic ovlSync, cdoutSync, rxASync, rxBSync;
	logic [2:0] divQ, divD;
	logic [4:0] bitCntQ, bitCntD;
	logic bitClkD, wordClkD, holdD, toggle, shiftEdge, sampleEdge;
	logic frameStart;
	logic [31:0] ctrlQ, ctrlD, txAQ, txAD, txBQ, txBD, txCQ, txCD;
	logic [31:0] txAuxQ, txAuxD, rxAWord, rxBWord, rdataD;
	logic wrReadyQ, wrReadyD, rdReadyD, bvalidD, rvalidD, spiStart;
	logic [1:0] brespD, rrespD;
	logic [7:0] wAddr, rAddr;
	spiState_t spiStateQ, spiStateD;
	logic [5:0] spiDivQ, spiDivD;
	logic [4:0] spiBitQ, spiBitD, spiEdgeQ;
	logic [23:0] spiShiftQ, spiShiftD;
	logic [7:0] readShiftQ, readShiftD, readByteQ, readByteD;
	logic spiClkD, csND, doutD;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			syncAQ <= 4'h0;
			syncBQ <= 4'h0;
		end else begin
			syncAQ <= {serialOutA, serialOutB, overloadFlag, controlDataPin};
			syncBQ <= syncAQ;
		end
	end
	assign {rxASync, rxBSync, ovlSync, cdoutSync} = syncBQ;

	// ----------------------------------------------------------------
	// frame timer: bit clock and word clock made by dividing core_clk
	// ----------------------------------------------------------------
	always_comb begin
		toggle = (divQ == BCLK_HALF_LAST);
		divD = toggle ? 3'h0 : 3'(divQ + 3'h1);
		bitClkD = toggle ? !portBitClock : portBitClock;
		// data changes on the edge the device does not latch on
		shiftEdge = toggle && (bitClkD == ctrlQ[CTRL_POL]);
		sampleEdge = toggle && (bitClkD != ctrlQ[CTRL_POL]);
		frameStart = shiftEdge && (bitCntQ == FRAME_LAST);
		bitCntD = shiftEdge ? 5'(bitCntQ + 5'h1) : bitCntQ;
		wordClkD = portWordClock;
		holdD = frameRepeatReq;
		if (frameStart) begin
			wordClkD = 1'b1;
			// request changes only at a frame boundary, whole frames held
			holdD = ctrlQ[CTRL_HOLD];
		end else if (shiftEdge && bitCntQ == HALF_LAST) begin
			wordClkD = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			divQ <= 3'h0;
			bitCntQ <= FRAME_LAST;
			portBitClock <= 1'b0;
			portWordClock <= 1'b0;
			auxBitClock <= 1'b0;
			auxWordClock <= 1'b0;
			frameRepeatReq <= 1'b0;
		end else begin
			divQ <= divD;
			bitCntQ <= bitCntD;
			portBitClock <= bitClkD;
			portWordClock <= wordClkD;
			auxBitClock <= bitClkD;
			auxWordClock <= wordClkD;
			frameRepeatReq <= holdD;
		end
	end

	assign laneCtl.loadStrobe = frameStart;
	assign laneCtl.shiftStrobe = shiftEdge && !frameStart;
	assign laneCtl.sampleStrobe = sampleEdge;

	// ----------------------------------------------------------------
	// serial lanes
	// ----------------------------------------------------------------
	frame_lane laneA (.core_clk(core_clk), .srst(srst), .ctl(laneCtl),
		.txWord(txAQ), .rxBit(rxASync), .txBit(serialInA),
		.rxWord(rxAWord));
	frame_lane laneB (.core_clk(core_clk), .srst(srst), .ctl(laneCtl),
		.txWord(txBQ), .rxBit(rxBSync), .txBit(serialInB),
		.rxWord(rxBWord));
	frame_lane laneC (.core_clk(core_clk), .srst(srst), .ctl(laneCtl),
		.txWord(txCQ), .rxBit(1'b0), .txBit(serialInC),
		.rxWord());
	frame_lane laneAux (.core_clk(core_clk), .srst(srst), .ctl(laneCtl),
		.txWord(txAuxQ), .rxBit(1'b0), .txBit(auxDataIn),
		.rxWord());

	// ----------------------------------------------------------------
	// axi4-lite register slave
	// ----------------------------------------------------------------
	always_comb begin
		ctrlD = ctrlQ;
		txAD = txAQ;
		txBD = txBQ;
		txCD = txCQ;
		txAuxD = txAuxQ;
		wrReadyD = 1'b0;
		rdReadyD = 1'b0;
		bvalidD = bvalid;
		brespD = bresp;
		rvalidD = rvalid;
		rrespD = rresp;
		rdataD = rdata;
		spiStart = 1'b0;
		wAddr = {awaddr[7:2], 2'h0};
		rAddr = {araddr[7:2], 2'h0};
		if (bvalid && bready) begin
			bvalidD = 1'b0;
		end
		if (rvalid && rready) begin
			rvalidD = 1'b0;
		end
		if (awvalid && wvalid && !bvalid && !wrReadyQ) begin
			wrReadyD = 1'b1;
		end
		if (arvalid && !rvalid && !arready) begin
			rdReadyD = 1'b1;
		end
		if (wrReadyQ) begin
			bvalidD = 1'b1;
			brespD = RESP_OKAY;
			case (wAddr)
				ADDR_CTRL: ctrlD = merge(ctrlQ, wdata, wstrb);
				// busy, i2c strap or powered down: command dropped
				ADDR_SPI_CMD: spiStart = (spiStateQ == SPI_IDLE) &&
					!ctrlQ[CTRL_I2C] && ctrlQ[CTRL_POWER_UP];
				ADDR_TX_A: txAD = merge(txAQ, wdata, wstrb);
				ADDR_TX_B: txBD = merge(txBQ, wdata, wstrb);
				ADDR_TX_C: txCD = merge(txCQ, wdata, wstrb);
				ADDR_TX_AUX: txAuxD = merge(txAuxQ, wdata, wstrb);
				ADDR_STATUS, ADDR_RX_A, ADDR_RX_B: brespD = RESP_OKAY;
				default: brespD = RESP_SLVERR;
			endcase
		end
		if (arready) begin
			rvalidD = 1'b1;
			rrespD = RESP_OKAY;
			case (rAddr)
				ADDR_CTRL: rdataD = ctrlQ;
				ADDR_SPI_CMD: rdataD = {8'h00, spiShiftQ};
				ADDR_STATUS: rdataD = {16'h0000, readByteQ, 6'h00, ovlSync,
					spiStateQ != SPI_IDLE};
				ADDR_TX_A: rdataD = txAQ;
				ADDR_TX_B: rdataD = txBQ;
				ADDR_TX_C: rdataD = txCQ;
				ADDR_TX_AUX: rdataD = txAuxQ;
				ADDR_RX_A: rdataD = rxAWord;
				ADDR_RX_B: rdataD = rxBWord;
				default: begin
					rdataD = WORD_RESET;
					rrespD = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrlQ <= CTRL_RESET;
			txAQ <= WORD_RESET;
			txBQ <= WORD_RESET;
			txCQ <= WORD_RESET;
			txAuxQ <= WORD_RESET;
			wrReadyQ <= 1'b0;
			arready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= WORD_RESET;
			powerDownInputN <= 1'b0;
			controlFormatSel <= 1'b0;
			deemphPinN <= 1'b1;
		end else begin
			ctrlQ <= ctrlD;
			txAQ <= txAD;
			txBQ <= txBD;
			txCQ <= txCD;
			txAuxQ <= txAuxD;
			wrReadyQ <= wrReadyD;
			arready <= rdReadyD;
			bvalid <= bvalidD;
			bresp <= brespD;
			rvalid <= rvalidD;
			rresp <= rrespD;
			rdata <= rdataD;
			powerDownInputN <= ctrlQ[CTRL_POWER_UP];
			controlFormatSel <= ctrlQ[CTRL_I2C];
			deemphPinN <= !ctrlQ[CTRL_DEEMPH];
		end
	end
	assign awready = wrReadyQ;
	assign wready = wrReadyQ;

	// ----------------------------------------------------------------
	// spi control master: 24 bits msb first, device latches on rise
	// ----------------------------------------------------------------
	always_comb begin
		spiStateD = spiStateQ;
		spiDivD = spiDivQ;
		spiBitD = spiBitQ;
		spiShiftD = spiShiftQ;
		readShiftD = readShiftQ;
		readByteD = readByteQ;
		spiClkD = controlInterfaceClock;
		csND = sharedAddr0SelectN;
		doutD = sharedAddr1Datain;
		unique case (spiStateQ)
			SPI_IDLE: begin
				if (spiStart) begin
					spiShiftD = wdata[23:0];
					doutD = wdata[23];
					csND = 1'b0;
					spiBitD = SPI_LAST_BIT;
					spiDivD = 6'h00;
					spiStateD = SPI_LOW;
				end
			end
			SPI_LOW: begin
				spiDivD = 6'(spiDivQ + 6'h01);
				if (spiDivQ == SPI_HALF_LAST) begin
					spiDivD = 6'h00;
					spiClkD = 1'b1;
					readShiftD = {readShiftQ[6:0], cdoutSync};
					spiStateD = SPI_HIGH;
				end
			end
			SPI_HIGH: begin
				spiDivD = 6'(spiDivQ + 6'h01);
				if (spiDivQ == SPI_HALF_LAST) begin
					spiDivD = 6'h00;
					spiClkD = 1'b0;
					if (spiBitQ == 5'h00) begin
						csND = 1'b1;
						readByteD = readShiftQ;
						spiStateD = SPI_IDLE;
					end else begin
						spiBitD = 5'(spiBitQ - 5'h01);
						spiShiftD = {spiShiftQ[22:0], 1'b0};
						doutD = spiShiftQ[22];
						spiStateD = SPI_LOW;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			spiStateQ <= SPI_IDLE;
			spiDivQ <= 6'h00;
			spiBitQ <= 5'h00;
			spiShiftQ <= 24'h000000;
			readShiftQ <= 8'h00;
			readByteQ <= 8'h00;
			controlInterfaceClock <= 1'b0;
			sharedAddr0SelectN <= 1'b1;
			sharedAddr1Datain <= 1'b0;
		end else begin
			spiStateQ <= spiStateD;
			spiDivQ <= spiDivD;
			spiBitQ <= spiBitD;
			spiShiftQ <= spiShiftD;
			readShiftQ <= readShiftD;
			readByteQ <= readByteD;
			controlInterfaceClock <= spiClkD;
			sharedAddr0SelectN <= csND;
			sharedAddr1Datain <= doutD;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// helper: rising clock edges inside one select window
	always_ff @(posedge core_clk) begin
		if (srst || spiStart) begin
			spiEdgeQ <= 5'h00;
		end else if (!controlInterfaceClock && spiClkD) begin
			spiEdgeQ <= 5'(spiEdgeQ + 5'h01);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence cmdTaken;
		spiStart;
	endsequence
	sequence selectHeld;
		!sharedAddr0SelectN [*2];
	endsequence

	a_lane_a_load: assert property (laneCtl.loadStrobe |=>
		serialInA == $past(txAQ[31])) else $error("lane a msb wrong");
	a_lane_b_load: assert property (laneCtl.loadStrobe |=>
		serialInB == $past(txBQ[31])) else $error("lane b msb wrong");
	a_lane_c_load: assert property (laneCtl.loadStrobe |=>
		serialInC == $past(txCQ[31])) else $error("lane c msb wrong");
	a_bit_clock_half: assert property ($changed(portBitClock) |=>
		$stable(portBitClock) [*3]) else $error("bit clock half short");
	a_word_clock_frame: assert property ($rose(portWordClock) |->
		bitCntQ == 5'h00 && $past(bitCntQ) == FRAME_LAST)
		else $error("word clock off frame");
	a_aux_clock_pair: assert property (auxBitClock == portBitClock &&
		auxWordClock == portWordClock) else $error("aux clocks differ");
	a_aux_lane_load: assert property (laneCtl.loadStrobe |=>
		auxDataIn == $past(txAuxQ[31])) else $error("aux lane msb wrong");
	a_spi_select_run: assert property (cmdTaken |=> selectHeld)
		else $error("select not asserted");
	a_spi_edge_count: assert property ($rose(sharedAddr0SelectN) |->
		spiEdgeQ == SPI_BITS) else $error("spi edge count wrong");
	a_spi_data_hold: assert property ($rose(controlInterfaceClock) |->
		$stable(sharedAddr1Datain)) else $error("spi data moved");
	a_power_follow: assert property (!ctrlQ[CTRL_POWER_UP] |=>
		!powerDownInputN) else $error("power-down pin not low");

endmodule

`default_nettype wire

// *** src/codec_host_pkg.sv ***
// codec host controller: shared constants, register map and types
// assumes a 100 MHz core clock; all times are converted to cycles here
package codec_host_pkg;

	// ----------------------------------------------------------------
	// clocking
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned BCLK_HALF_NS = 40;
	localparam int unsigned BCLK_HALF_CYC = BCLK_HALF_NS / CLK_PERIOD_NS;
	localparam logic [2:0] BCLK_HALF_LAST = 3'(BCLK_HALF_CYC - 1);
	localparam int unsigned SPI_HALF_NS = 500;
	localparam int unsigned SPI_HALF_CYC = SPI_HALF_NS / CLK_PERIOD_NS;
	localparam logic [5:0] SPI_HALF_LAST = 6'(SPI_HALF_CYC - 1);

	// ----------------------------------------------------------------
	// serial frame
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W = 32;
	localparam logic [4:0] FRAME_LAST = 5'h1f;
	localparam logic [4:0] HALF_LAST = 5'h0f;
	localparam logic [4:0] SPI_LAST_BIT = 5'h17;
	localparam logic [4:0] SPI_BITS = 5'h18;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SPI_CMD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_TX_A = 8'h10;
	localparam logic [7:0] ADDR_TX_B = 8'h14;
	localparam logic [7:0] ADDR_TX_C = 8'h18;
	localparam logic [7:0] ADDR_TX_AUX = 8'h1c;
	localparam logic [7:0] ADDR_RX_A = 8'h20;
	localparam logic [7:0] ADDR_RX_B = 8'h24;
	localparam int unsigned CTRL_POWER_UP = 0;
	localparam int unsigned CTRL_I2C = 1;
	localparam int unsigned CTRL_POL = 2;
	localparam int unsigned CTRL_DEEMPH = 3;
	localparam int unsigned CTRL_HOLD = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SPI_IDLE, SPI_LOW, SPI_HIGH} spiState_t;

endpackage

// *** src/frame_lane.sv ***
// one serial lane: 32-bit word out msb first, 32-bit word in msb first
// assumes strobes from the frame timer; rxBit already synchronised
`timescale 1ns/1ps
`default_nettype none

module frame_lane (
	input wire logic core_clk,
	input wire logic srst,
	lane_ctl_if.lane ctl,
	input wire logic [31:0] txWord,
	input wire logic rxBit,
	output logic txBit,
	output logic [31:0] rxWord
);
	import codec_host_pkg::*;

	logic [31:0] txShiftQ, txShiftD, rxShiftQ, rxShiftD, rxWordD;

	// ----------------------------------------------------------------
	// shifters
	// ----------------------------------------------------------------
	always_comb begin
		txShiftD = txShiftQ;
		rxShiftD = rxShiftQ;
		rxWordD = rxWord;
		if (ctl.loadStrobe) begin
			txShiftD = txWord;
			// a frame is complete once the next one starts
			rxWordD = rxShiftQ;
		end else if (ctl.shiftStrobe) begin
			txShiftD = {txShiftQ[30:0], 1'b0};
		end
		if (ctl.sampleStrobe) begin
			rxShiftD = {rxShiftQ[30:0], rxBit};
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			txShiftQ <= WORD_RESET;
			rxShiftQ <= WORD_RESET;
			rxWord <= WORD_RESET;
		end else begin
			txShiftQ <= txShiftD;
			rxShiftQ <= rxShiftD;
			rxWord <= rxWordD;
		end
	end

	assign txBit = txShiftQ[31];

endmodule

`default_nettype wire

// *** src/lane_ctl_if.sv ***
// frame timing strobes shared by every serial lane
// assumes all strobes are one-cycle pulses on core_clk
`timescale 1ns/1ps
`default_nettype none

interface lane_ctl_if;
	logic loadStrobe;
	logic shiftStrobe;
	logic sampleStrobe;
	modport ctrl (output loadStrobe, output shiftStrobe, output sampleStrobe);
	modport lane (input loadStrobe, input shiftStrobe, input sampleStrobe);
endinterface

`default_nettype wire

// *** verif/codec_model.sv ***
// partner model of the codec: serial audio port, aux input, spi port
// assumes every pin is sampled on core_clk, far faster than the links
`timescale 1ns/1ps
`default_nettype none

module codec_model (
	input wire logic core_clk,
	input wire logic portBitClock,
	input wire logic portWordClock,
	input wire logic serialInA,
	input wire logic serialInB,
	input wire logic serialInC,
	output logic serialOutA,
	output logic serialOutB,
	input wire logic deemphPinN,
	output logic overloadFlag,
	input wire logic auxDataIn,
	input wire logic auxWordClock,
	input wire logic auxBitClock,
	input wire logic frameRepeatReq,
	input wire logic controlFormatSel,
	input wire logic controlInterfaceClock,
	input wire logic sharedAddr0SelectN,
	input wire logic sharedAddr1Datain,
	output logic controlDataPin,
	input wire logic powerDownInputN,
	input wire logic clip,
	input wire logic [31:0] stereoWord,
	input wire logic [31:0] monoWord,
	output logic [31:0] dacA,
	output logic [31:0] dacB,
	output logic [31:0] dacC,
	output logic [9:0] mclkRatio,
	output logic deemphOn,
	output logic muted
);
	// ----------------------------------------------------------------
	// device behaviour
	// ----------------------------------------------------------------
	// only the bytes the host touches are modelled; others read zero
	logic [7:0] regs [32];
	logic [31:0] shA, shB, shC, shX, oA, oB, auxGood, selA, selB;
	logic bcP, abP, ccP, wcP, wcL, awP, held, pol, lat, lau, conv;
	logic [23:0] cin;
	logic [7:0] cout;
	logic [4:0] nb, holdCnt;
	logic [1:0] route;
	logic [2:0] dsel;
	assign pol = regs[14][3];
	assign lat = pol ? bcP & ~portBitClock : ~bcP & portBitClock;
	assign lau = pol ? ~bcP & portBitClock : bcP & ~portBitClock;
	assign conv = ~regs[2][0];
	assign route = regs[11][7:6];
	assign dsel = regs[16][2:0];
	assign selA = (route == 2'h1 || route == 2'h2) ? auxGood :
		conv ? stereoWord : 32'h0;
	assign selB = route == 2'h2 ? stereoWord : conv ? monoWord : 32'h0;
	assign serialOutA = oA[31];
	assign serialOutB = oB[31];
	assign overloadFlag = clip;
	assign deemphOn = (dsel inside {[3'h1:3'h3]}) ||
		(dsel inside {[3'h4:3'h6]} && !deemphPinN);
	assign muted = holdCnt[4] && !regs[16][4];
	// master clock output shown as its ratio to the sample rate
	assign mclkRatio = (regs[1][6:5] == 2'h3) ? 10'h001 :
		{3'(regs[1][6:5]) + 3'h2, 7'h00};
	always @(posedge core_clk) begin
		bcP <= portBitClock;
		abP <= auxBitClock;
		ccP <= controlInterfaceClock;
		if (!powerDownInputN) begin
			foreach (regs[i]) regs[i] <= 8'h00;
			regs[2] <= 8'h01;
			nb <= 5'h0;
			holdCnt <= 5'h0;
			held <= 1'b0;
			auxGood <= 32'h0;
			oA <= 32'h0;
			oB <= 32'h0;
			controlDataPin <= 1'b0;
		end else begin
			if (lat) begin
				shA <= {shA[30:0], serialInA};
				shB <= {shB[30:0], serialInB};
				shC <= {shC[30:0], serialInC};
				wcP <= portWordClock;
				if (portWordClock && !wcP && conv) begin
					dacA <= shA;
					dacB <= shB;
					dacC <= shC;
				end
			end
			if (lau) begin
				wcL <= portWordClock;
				oA <= (portWordClock && !wcL) ? selA : oA << 1;
				oB <= (portWordClock && !wcL) ? selB : oB << 1;
			end
			// aux port taken on the rising edge only, the reset polarity
			if (~abP & auxBitClock) begin
				shX <= {shX[30:0], auxDataIn};
				awP <= auxWordClock;
				held <= held | frameRepeatReq;
				if (auxWordClock && !awP) begin
					held <= frameRepeatReq;
					if (!held) auxGood <= shX;
					holdCnt <= !held ? 5'h0 :
						holdCnt[4] ? holdCnt : holdCnt + 5'h1;
				end
			end
			if (!controlFormatSel && !sharedAddr0SelectN) begin
				if (~ccP & controlInterfaceClock) begin
					cin <= {cin[22:0], sharedAddr1Datain};
					nb <= nb + 5'h1;
				end
				if (ccP & ~controlInterfaceClock && nb >= 5'h10) begin
					cout <= (nb == 5'h10) ? regs[cin[4:0]] << 1 : cout << 1;
					controlDataPin <= (nb == 5'h10) ? regs[cin[4:0]][7] : cout[7];
				end
			end else begin
				if (nb == 5'h18 && !cin[16]) regs[cin[12:8]] <= cin[7:0];
				nb <= 5'h0;
				// released line: toggle so a stale bit is never read as data
				controlDataPin <= ~controlDataPin;
			end
		end
	end
endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench: axi4-lite orders to the host, codec model beyond
// assumes the package register map and a 100 MHz core clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin nErrors++; \
	$display("MISMATCH %0t got %h expected %h", $time, g, e); end end

module tb_top;
	import codec_host_pkg::*;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic core_clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, clip, deemphOn, muted;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, stereoWord, monoWord, dacA, dacB, dacC;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic serialInA, serialInB, serialInC, serialOutA, serialOutB;
	logic portBitClock, portWordClock, deemphPinN, overloadFlag, auxDataIn;
	logic auxWordClock, auxBitClock, frameRepeatReq, controlFormatSel;
	logic controlInterfaceClock, sharedAddr0SelectN, sharedAddr1Datain;
	logic controlDataPin, powerDownInputN;
	logic [9:0] mclkRatio;
	int nErrors, checked;
	codec_host_ctrl i_dut (.core_clk, .srst, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .serialInA,
		.serialInB, .serialInC, .serialOutA, .serialOutB, .portBitClock,
		.portWordClock, .deemphPinN, .overloadFlag, .auxDataIn, .auxWordClock,
		.auxBitClock, .frameRepeatReq, .controlFormatSel,
		.controlInterfaceClock, .sharedAddr0SelectN, .sharedAddr1Datain,
		.controlDataPin, .powerDownInputN);
	codec_model i_model (.core_clk, .portBitClock, .portWordClock,
		.serialInA, .serialInB, .serialInC, .serialOutA, .serialOutB,
		.deemphPinN, .overloadFlag, .auxDataIn, .auxWordClock, .auxBitClock,
		.frameRepeatReq, .controlFormatSel, .controlInterfaceClock,
		.sharedAddr0SelectN, .sharedAddr1Datain, .controlDataPin,
		.powerDownInputN, .clip, .stereoWord, .monoWord, .dacA, .dacB, .dacC,
		.deemphOn, .muted, .mclkRatio);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	// each starts on a fresh edge so no strobe is set twice in one step
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge core_clk);
			if (awready === 1'b1) begin
				awvalid <= 1'b0;
				aw = 1'b1;
			end
			if (wready === 1'b1) begin
				wvalid <= 1'b0;
				w = 1'b1;
			end
		end
		while (bvalid !== 1'b1) @(posedge core_clk);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic axiRd(input logic [7:0] a);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic spiRun(input logic [23:0] cmd);
		axiWr(ADDR_SPI_CMD, {8'h00, cmd});
		do axiRd(ADDR_STATUS); while (rd[0] !== 1'b0);
	endtask
	task automatic end_sim;
		if (nErrors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge core_clk);
		nErrors++;
		end_sim();
	end
	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		{srst, awvalid, wvalid, bready, arvalid, rready, clip} = 7'h40;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		stereoWord = 32'hc0de_1234;
		monoWord = 32'h5a5a_0ff1;
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		axiRd(ADDR_CTRL);
		`CHK({rs, rd}, {RESP_OKAY, CTRL_RESET})
		`CHK(powerDownInputN, 1'b0)
		`CHK(sharedAddr0SelectN, 1'b1)
		axiWr(8'h40, 32'h1);
		`CHK(rs, RESP_SLVERR)
		axiRd(8'h44);
		`CHK({rs, rd}, {RESP_SLVERR, WORD_RESET})
		axiWr(ADDR_STATUS, 32'h0);
		`CHK(rs, RESP_OKAY)
		for (int v = 0; v < 4; v += 3) begin
			axiWr(ADDR_CTRL, 32'(v));
			axiWr(ADDR_SPI_CMD, 32'h20_02_01);
			axiRd(ADDR_STATUS);
			`CHK(rd[0], 1'b0)
			`CHK(controlFormatSel, 1'(v >> 1))
		end
		for (int k = 0; k < 2; k++) begin
			axiWr(ADDR_CTRL, 32'h0);
			axiWr(ADDR_CTRL, 32'h1);
			spiRun(24'h21_02_00);
			`CHK(rd[15:8], 8'h01)
			`CHK(mclkRatio, 10'h100)
			`CHK(powerDownInputN, 1'b1)
			spiRun(24'h20_02_00);
			spiRun(24'h21_02_00);
			`CHK(rd[15:8], 8'h00)
		end
		spiRun(24'h20_01_60);
		`CHK(mclkRatio, 10'h001)
		for (int c = 0; c < 7; c++) begin
			spiRun({16'h20_10, 5'h0, 3'(c)});
			for (int p = 0; p < 2; p++) begin
				axiWr(ADDR_CTRL, 32'(1 | (p << CTRL_DEEMPH)));
				repeat (2) @(posedge core_clk);
				`CHK(deemphOn, (c inside {[1:3]}) || (c > 3 && p == 1))
			end
		end
		for (int p = 1; p >= 0; p--) begin
			spiRun({16'h20_0e, 4'h0, 1'(p), 3'h0});
			axiWr(ADDR_CTRL, 32'(1 | (p << CTRL_POL)));
			axiWr(ADDR_TX_A, 32'h8123_4567 + 32'(p));
			axiWr(ADDR_TX_B, 32'h9abc_def0 + 32'(p));
			axiWr(ADDR_TX_C, 32'h0f1e_2d3c + 32'(p));
			axiRd(ADDR_TX_C);
			`CHK(rd, 32'h0f1e_2d3c + 32'(p))
			repeat (1024) @(posedge core_clk);
			`CHK(dacA, 32'h8123_4567 + 32'(p))
			`CHK(dacB, 32'h9abc_def0 + 32'(p))
			`CHK(dacC, 32'h0f1e_2d3c + 32'(p))
			axiRd(ADDR_RX_A);
			`CHK(rd, stereoWord)
			axiRd(ADDR_RX_B);
			`CHK(rd, monoWord)
		end
		axiWr(ADDR_TX_AUX, 32'h3c5a_96e1);
		for (int r = 1; r < 3; r++) begin
			spiRun({16'h20_0b, 2'(r), 6'h0});
			repeat (1536) @(posedge core_clk);
			axiRd(ADDR_RX_A);
			`CHK(rd, 32'h3c5a_96e1)
			axiRd(ADDR_RX_B);
			`CHK(rd, r == 2 ? stereoWord : monoWord)
		end
		axiWr(ADDR_CTRL, 32'h11);
		axiWr(ADDR_TX_AUX, 32'h7e81_24db);
		repeat (6144) @(posedge core_clk);
		axiRd(ADDR_RX_A);
		`CHK(rd, 32'h3c5a_96e1)
		`CHK(muted, 1'b1)
		spiRun(24'h20_10_16);
		`CHK(muted, 1'b0)
		spiRun(24'h20_10_06);
		`CHK(muted, 1'b1)
		axiWr(ADDR_CTRL, 32'h1);
		repeat (1536) @(posedge core_clk);
		axiRd(ADDR_RX_A);
		`CHK(rd, 32'h7e81_24db)
		`CHK(muted, 1'b0)
		for (int v = 1; v >= 0; v--) begin
			clip <= 1'(v);
			repeat (4) @(posedge core_clk);
			axiRd(ADDR_STATUS);
			`CHK(rd[1], 1'(v))
		end
		end_sim();
	end
endmodule

`default_nettype wire
